// ==== tpe_pkg.sv ====
/*
 * Shared constants and carrier types for the timer prescaler and
 * edge-select block: register offsets, field positions, reset values,
 * edge and clock-select codes, divider taps and bus request struct.
 * Assumes one 100 MHz main clock and an 8-bit register port.
 */
package tpe_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_PORT7_DIR   = 16'hFF27;
    localparam logic [15:0] ADDR_PORT7_LATCH = 16'hFF07;
    localparam logic [15:0] ADDR_PRESCALE0   = 16'hFF61;
    localparam logic [15:0] ADDR_PRESCALE1   = 16'hFF65;
    localparam logic [15:0] ADDR_OUT_CTRL    = 16'hFF67;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] PORT7_DIR_RST    = 8'hFF;
    localparam logic [7:0] PORT7_FIXED_ONES = 8'hC0;
    localparam logic [7:0] PORT7_LATCH_RST  = 8'h00;
    localparam logic [7:0] PRESCALE_RST     = 8'h00;
    localparam logic [7:0] PRESCALE_MASK    = 8'hF3;
    localparam logic [7:0] OUT_CTRL_RST     = 8'h00;
    localparam logic [7:0] OUT_CTRL_KEEP    = 8'h13;
    localparam logic [7:0] READ_NONE        = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CLK_SEL_LSB  = 0;
    localparam int IN0_EDGE_LSB = 4;
    localparam int IN1_EDGE_LSB = 6;
    localparam int OC_OUT_EN    = 0;
    localparam int OC_INV_A     = 1;
    localparam int OC_CLR_CMD   = 2;
    localparam int OC_SET_CMD   = 3;
    localparam int OC_INV_B     = 4;
    localparam int SHARED_PIN0  = 0;
    localparam int SHARED_PIN5  = 5;
    localparam int PORT_W       = 6;

    // ------------------------------------------------------------
    // Codes and divider taps (exponents of two)
    // ------------------------------------------------------------
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] CSEL_TAP0 = 2'h0;
    localparam logic [1:0] CSEL_TAP1 = 2'h1;
    localparam logic [1:0] CSEL_TAP2 = 2'h2;
    localparam logic [1:0] CSEL_EXT  = 2'h3;
    localparam int DIV_W = 9;
    localparam int C0_EXP0 = 0;
    localparam int C0_EXP1 = 2;
    localparam int C0_EXP2 = 6;
    localparam int C1_EXP0 = 1;
    localparam int C1_EXP1 = 3;
    localparam int C1_EXP2 = 9;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } tpe_bus_req_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } tpe_edge_t;

endpackage : tpe_pkg

// ==== tpe_divider.sv ====
/*
 * Free-running divider on the main clock. Tap k pulses for one cycle
 * every 2**k cycles, so all count clocks stay in one clock domain.
 * Assumes synchronous active-low reset.
 */
module tpe_divider import tpe_pkg::*; #(
    parameter int W = DIV_W
) (
    input  wire logic         sys_clk_in,
    input  wire logic         reset_n_in,
    output logic [W:0]        taps_out
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } tpe_div_state_t;

    tpe_div_state_t st;
    tpe_div_state_t next_st;

    // ------------------------------------------------------------
    // Counter and tap decode
    // ------------------------------------------------------------
    always_comb begin
        next_st     = st;
        next_st.cnt = st.cnt + {{(W-1){1'b0}}, 1'b1};
        taps_out[0] = 1'b1;
        // Tap k fires when the low k bits are all ones
        for (int k = 1; k <= W; k++) begin
            taps_out[k] = &(st.cnt | ~((W)'((1 << k) - 1)));
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : tpe_divider

// ==== tpe_sampler.sv ====
/*
 * Input pin sampler: three-flop synchroniser, stable level once the
 * second and third stages agree, then a two-sample noise filter that
 * reports rising and falling edges of the accepted level.
 * Assumes the pin is asynchronous to sys_clk_in.
 */
module tpe_sampler import tpe_pkg::*; (
    input  wire logic  sys_clk_in,
    input  wire logic  reset_n_in,
    input  wire logic  pin_in,
    input  wire logic  sample_en_in,
    input  wire logic  track_en_in,
    output tpe_edge_t  edge_out
);

    typedef struct packed {
        logic      s1;
        logic      s2;
        logic      s3;
        logic      cand;
        logic      prev;
        logic      level;
        tpe_edge_t edge_p;
    } tpe_smp_state_t;

    tpe_smp_state_t st;
    tpe_smp_state_t next_st;

    assign edge_out = st.edge_p;

    // ------------------------------------------------------------
    // Synchroniser and filter
    // ------------------------------------------------------------
    always_comb begin
        next_st        = st;
        next_st.s1     = pin_in;
        next_st.s2     = st.s1;
        next_st.s3     = st.s2;
        next_st.edge_p = '0;
        // Level is believed only when the later stages agree
        if (st.s2 == st.s3) begin
            next_st.cand = st.s3;
        end
        if (sample_en_in) begin
            next_st.prev = st.cand;
            if (track_en_in && (st.prev == st.cand) && (st.cand != st.level)) begin
                next_st.level       = st.cand;
                next_st.edge_p.rise = st.cand;
                next_st.edge_p.fall = !st.cand;
            end
        end
    end

    // Level starts low, so a high pin gives one rising edge when
    // tracking is first enabled
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : tpe_sampler

// ==== tpe_timer_prescaler.sv ====
/*
 * Prescaler and input edge selection for two 16-bit timer/event
 * counters, with the shared port direction and latch registers and
 * the output control register of counter 1.
 * Assumes the counters, their mode control and compare logic sit
 * outside on the same 100 MHz clock, and that software reaches the
 * registers over a plain one-cycle strobe port.
 */
// Added by the designer: the strobed register port.

module tpe_timer_prescaler import tpe_pkg::*; (
    input  wire logic               sys_clk_in,
    input  wire logic               reset_n_in,
    input  wire tpe_bus_req_t       bus_req_in,
    output logic [7:0]              rd_data_out,
    input  wire logic [1:0]         shared_pin_in,
    input  wire logic [1:0]         second_in_in,
    input  wire logic [1:0]         run_in,
    input  wire logic               timer0_level_in,
    input  wire logic               cmp1_match_a_in,
    input  wire logic               cmp1_match_b_in,
    output logic [PORT_W-1:0]       port_pin_out,
    output logic [PORT_W-1:0]       port_pin_oe_out,
    output logic [1:0]              count_tick_out,
    output logic [1:0]              first_edge_out,
    output logic [1:0]              second_edge_out,
    output logic                    timer1_ff_out
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Edge code against an observed edge; prohibited code matches none
    function automatic logic edge_hit(input logic [1:0] sel, input tpe_edge_t ev);
        logic hit;
        hit = 1'b0;
        case (sel)
            EDGE_FALL: hit = ev.fall;
            EDGE_RISE: hit = ev.rise;
            EDGE_BOTH: hit = ev.rise | ev.fall;
            default:   hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // Internal tap for a counter and a select code
    function automatic logic tap_of(input logic ch, input logic [1:0] sel,
                                    input logic [DIV_W:0] taps);
        logic t;
        t = 1'b0;
        case (sel)
            CSEL_TAP0: t = ch ? taps[C1_EXP0] : taps[C0_EXP0];
            CSEL_TAP1: t = ch ? taps[C1_EXP1] : taps[C0_EXP1];
            CSEL_TAP2: t = ch ? taps[C1_EXP2] : taps[C0_EXP2];
            default:   t = 1'b0;
        endcase
        return t;
    endfunction : tap_of

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        dir;
        logic [7:0]        latch;
        logic [1:0][7:0]   pre;
        logic [7:0]        octl;
        logic [1:0]        started;
        logic              ff1;
        logic [7:0]        rdata;
        logic [1:0]        tick;
        logic [1:0]        fedge;
        logic [1:0]        sedge;
        logic [PORT_W-1:0] pout;
        logic [PORT_W-1:0] poe;
    } tpe_top_state_t;

    tpe_top_state_t st;
    tpe_top_state_t next_st;

    logic [DIV_W:0]  taps;
    logic [1:0]      int_tap;
    logic [1:0]      ext_sel;
    logic [1:0]      track;
    logic [1:0]      first_smp_en;
    logic [1:0]      second_smp_en;
    logic [1:0]      first_pin_is_in;
    tpe_edge_t [1:0] first_ev;
    tpe_edge_t [1:0] second_ev;
    logic [1:0]      first_hit;
    logic [1:0]      second_hit;

    // ------------------------------------------------------------
    // Divider and per-counter source selection
    // ------------------------------------------------------------

    tpe_divider #(
        .W (DIV_W)
    ) u_divider (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .taps_out   (taps)
    );

    // Shared pin 0 feeds counter 0, shared pin 5 counter 1
    assign first_pin_is_in[0] = st.dir[SHARED_PIN0];
    assign first_pin_is_in[1] = st.dir[SHARED_PIN5];

    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            ext_sel[ch] = (st.pre[ch][CLK_SEL_LSB +: 2] == CSEL_EXT);
            int_tap[ch] = tap_of(ch[0], st.pre[ch][CLK_SEL_LSB +: 2], taps);
            // tracking begins at the first run, then stays on
            track[ch] = run_in[ch] | st.started[ch];
            // external count clock sampled on every main clock
            first_smp_en[ch]  = ext_sel[ch] ? 1'b1 : int_tap[ch];
            second_smp_en[ch] = ext_sel[ch] ? 1'b1 : int_tap[ch];
        end
    end

    // ------------------------------------------------------------
    // Input samplers
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_inputs
        tpe_sampler u_first (
            .sys_clk_in   (sys_clk_in),
            .reset_n_in   (reset_n_in),
            .pin_in       (shared_pin_in[g]),
            .sample_en_in (first_smp_en[g]),
            .track_en_in  (track[g]),
            .edge_out     (first_ev[g])
        );

        tpe_sampler u_second (
            .sys_clk_in   (sys_clk_in),
            .reset_n_in   (reset_n_in),
            .pin_in       (second_in_in[g]),
            .sample_en_in (second_smp_en[g]),
            .track_en_in  (track[g]),
            .edge_out     (second_ev[g])
        );
    end

    // Edge qualification against the select fields
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            // input function lost while pin drives output
            first_hit[ch] = first_pin_is_in[ch] &
                            edge_hit(st.pre[ch][IN0_EDGE_LSB +: 2], first_ev[ch]);
            second_hit[ch] = edge_hit(st.pre[ch][IN1_EDGE_LSB +: 2], second_ev[ch]);
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.rdata = READ_NONE;

        // Count ticks and qualified edges, only while running
        for (int ch = 0; ch < 2; ch++) begin
            next_st.tick[ch]  = run_in[ch] &
                                (ext_sel[ch] ? first_hit[ch] : int_tap[ch]);
            next_st.fedge[ch] = run_in[ch] & first_hit[ch];
            next_st.sedge[ch] = run_in[ch] & second_hit[ch];
            // no fresh edge on a later restart
            if (run_in[ch]) begin
                next_st.started[ch] = 1'b1;
            end
        end

        // Output flip-flop toggles when exactly one enabled compare match occurs; two together cancel
        if ((cmp1_match_a_in & st.octl[OC_INV_A]) ^
            (cmp1_match_b_in & st.octl[OC_INV_B])) begin
            next_st.ff1 = !st.ff1;
        end

        // Register writes
        if (bus_req_in.wr) begin
            case (bus_req_in.addr)
                ADDR_PORT7_DIR: begin
                    next_st.dir = bus_req_in.wdata | PORT7_FIXED_ONES;
                end
                ADDR_PORT7_LATCH: begin
                    next_st.latch = bus_req_in.wdata;
                end
                ADDR_PRESCALE0: begin
                    // bits 2 and 3 never stored
                    next_st.pre[0] = bus_req_in.wdata & PRESCALE_MASK;
                end
                ADDR_PRESCALE1: begin
                    next_st.pre[1] = bus_req_in.wdata & PRESCALE_MASK;
                end
                ADDR_OUT_CTRL: begin
                    // command bits act once, never stored
                    next_st.octl = bus_req_in.wdata & OUT_CTRL_KEEP;
                    // Command wins over a match in the same cycle
                    if (bus_req_in.wdata[OC_SET_CMD] && !bus_req_in.wdata[OC_CLR_CMD]) begin
                        next_st.ff1 = 1'b1;
                    end else if (bus_req_in.wdata[OC_CLR_CMD] &&
                                 !bus_req_in.wdata[OC_SET_CMD]) begin
                        next_st.ff1 = 1'b0;
                    end
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end

        // Register reads, answered one cycle later
        if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                ADDR_PORT7_DIR:   next_st.rdata = st.dir;
                ADDR_PORT7_LATCH: next_st.rdata = st.latch;
                ADDR_PRESCALE0:   next_st.rdata = st.pre[0];
                ADDR_PRESCALE1:   next_st.rdata = st.pre[1];
                ADDR_OUT_CTRL:    next_st.rdata = st.octl;
                default:          next_st.rdata = READ_NONE;
            endcase
        end

        // Pin drivers
        for (int k = 0; k < PORT_W; k++) begin
            // direction 0 turns the buffer on
            next_st.poe[k]  = !st.dir[k];
            next_st.pout[k] = st.latch[k];
        end
        // timer output ORed onto a latch held at zero
        next_st.pout[SHARED_PIN0] = st.latch[SHARED_PIN0] | timer0_level_in;
        next_st.pout[SHARED_PIN5] = st.latch[SHARED_PIN5] |
                                    (st.ff1 & st.octl[OC_OUT_EN]);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            st       <= '0;
            st.dir   <= PORT7_DIR_RST;
            st.latch <= PORT7_LATCH_RST;
            st.pre   <= {PRESCALE_RST, PRESCALE_RST};
            st.octl  <= OUT_CTRL_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign rd_data_out     = st.rdata;
    assign port_pin_out    = st.pout;
    assign port_pin_oe_out = st.poe;
    assign count_tick_out  = st.tick;
    assign first_edge_out  = st.fedge;
    assign second_edge_out = st.sedge;
    assign timer1_ff_out   = st.ff1;

endmodule : tpe_timer_prescaler

// ==== tpe_pulse_src.sv ====
/* Partner model: an external pulse source on a timer input pin.
   Assumes the bench clock and an enable from the bench. */
module tpe_pulse_src (
    input  wire logic clk_in,
    input  wire logic en_in,
    output logic      pin_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    initial pin_out = 1'b0;
    // each level held 20 clocks
    // Idle source keeps its last level, like a real driver
    always @(posedge clk_in) begin
        if (en_in) begin
            cnt <= (cnt == 19) ? 0 : cnt + 1;
            if (cnt == 19) begin
                pin_out <= ~pin_out;
            end
        end
    end
endmodule : tpe_pulse_src

// ==== tpe_timer_prescaler_chk.sv ====
/* Concurrent checks on the prescaler ports.
   Assumes one clock and the one-cycle strobe register port. */
module tpe_timer_prescaler_chk import tpe_pkg::*; (
    input wire logic              sys_clk_in,
    input wire logic              reset_n_in,
    input wire tpe_bus_req_t      bus_req_in,
    input wire logic [7:0]        rd_data_out,
    input wire logic [1:0]        run_in,
    input wire logic [PORT_W-1:0] port_pin_oe_out,
    input wire logic [1:0]        count_tick_out,
    input wire logic [1:0]        first_edge_out,
    input wire logic              timer1_ff_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [7:0] dir_sh;
    logic [7:0] psc0_sh;
    logic [7:0] psc1_sh;
    logic       dir_wr;
    assign dir_wr = bus_req_in.wr && bus_req_in.addr == ADDR_PORT7_DIR;
    // Shadows of written values; design reads them back masked
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            dir_sh <= 8'hFF;
            psc0_sh <= 8'h00;
            psc1_sh <= 8'h00;
        end else if (bus_req_in.wr) begin
            if (dir_wr) dir_sh <= bus_req_in.wdata | 8'hC0;
            if (bus_req_in.addr == ADDR_PRESCALE0) psc0_sh <= bus_req_in.wdata;
            if (bus_req_in.addr == ADDR_PRESCALE1) psc1_sh <= bus_req_in.wdata;
        end
    end
    dir_top_ones_a: assert property (
        $past(bus_req_in.rd) && $past(bus_req_in.addr) == ADDR_PORT7_DIR
        |-> rd_data_out[7:6] == 2'h3) else $error("direction top bits not one");
    psc_readback_a: assert property (
        $past(bus_req_in.rd) && $past(bus_req_in.addr) == ADDR_PRESCALE0
        |-> rd_data_out == (psc0_sh & 8'hF3)) else $error("prescale readback wrong");
    ctrl_cmd_zero_a: assert property (
        $past(bus_req_in.rd) && $past(bus_req_in.addr) == ADDR_OUT_CTRL
        |-> rd_data_out[7:5] == 3'h0 && rd_data_out[3:2] == 2'h0)
        else $error("control command bits not zero");
    oe_follows_dir_a: assert property (
        (!dir_wr) [*2] |-> port_pin_oe_out == ~dir_sh[PORT_W-1:0])
        else $error("output enable does not follow direction");
    edge_needs_input_a: assert property (
        first_edge_out[0] |-> dir_sh[SHARED_PIN0] && psc0_sh[5:4] != 2'h2)
        else $error("first edge while output or prohibited code");
    tick0_div4_a: assert property (
        count_tick_out[0] && psc0_sh[1:0] == CSEL_TAP1 |-> !$past(count_tick_out[0])
        && !$past(count_tick_out[0], 2) && !$past(count_tick_out[0], 3)
        && ($past(count_tick_out[0], 4) || !$past(run_in[0], 7)))
        else $error("counter 0 divide by 4 spacing wrong");
    tick1_div2_a: assert property (
        count_tick_out[1] && psc1_sh[1:0] == CSEL_TAP0 |-> !$past(count_tick_out[1])
        && ($past(count_tick_out[1], 2) || !$past(run_in[1], 5)))
        else $error("counter 1 divide by 2 spacing wrong");
    tick_needs_run_a: assert property (
        (run_in == 2'h0) [*3] |-> count_tick_out == 2'h0 && first_edge_out == 2'h0)
        else $error("pulse while stopped");
    ff_command_a: assert property (
        bus_req_in.wr && bus_req_in.addr == ADDR_OUT_CTRL && ^bus_req_in.wdata[3:2]
        |=> timer1_ff_out == $past(bus_req_in.wdata[OC_SET_CMD]))
        else $error("output flip-flop command ignored");
endmodule : tpe_timer_prescaler_chk

bind tpe_timer_prescaler tpe_timer_prescaler_chk u_chk (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .bus_req_in(bus_req_in),
    .rd_data_out(rd_data_out), .run_in(run_in), .port_pin_oe_out(port_pin_oe_out),
    .count_tick_out(count_tick_out), .first_edge_out(first_edge_out),
    .timer1_ff_out(timer1_ff_out));

// ==== tpe_timer_prescaler_tb.sv ====
/* Self-checking bench: register port, taps, edge codes, sampler
   filter and pin direction. Assumes tpe_pulse_src on pin 0. */
module tpe_timer_prescaler_tb import tpe_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic              sys_clk_in, reset_n_in, src_en, src_pin, pin1, t0_lvl, m_a, m_b, ff;
    logic [1:0]        run, tick, e1st, e2nd;
    logic [7:0]        rd_data;
    logic [PORT_W-1:0] pin_o, oe_o;
    tpe_bus_req_t      req;
    int                bad_count = 0;
    int                samples_checked = 0;

    tpe_pulse_src SRC (.clk_in(sys_clk_in), .en_in(src_en), .pin_out(src_pin));
    tpe_timer_prescaler DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .bus_req_in(req), .rd_data_out(rd_data), .shared_pin_in({pin1, src_pin}),
        .second_in_in({pin1, src_pin}), .run_in(run), .timer0_level_in(t0_lvl),
        .cmp1_match_a_in(m_a), .cmp1_match_b_in(m_b), .port_pin_out(pin_o),
        .port_pin_oe_out(oe_o), .count_tick_out(tick), .first_edge_out(e1st),
        .second_edge_out(e2nd), .timer1_ff_out(ff));

    // Free-running 100 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t value %h expected %h", $time, g, e);
        end
    endtask : chk8

    task automatic chkn(input int g, input int e);
        samples_checked++;
        if (g != e) begin
            bad_count++;
            $display("ERROR %0t count %0d expected %0d", $time, g, e);
        end
    endtask : chkn

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        req.rd <= 1'b0;
        #1 chk8(rd_data, e);
    endtask : rd_chk

    // Pulses of counter k over n cycles: ticks, first and second edges
    task automatic cnt(input int k, input int n, output int t, output int f, output int s);
        t = 0;
        f = 0;
        s = 0;
        repeat (n) begin
            @(posedge sys_clk_in);
            #1;
            t += int'(tick[k] === 1'b1);
            f += int'(e1st[k] === 1'b1);
            s += int'(e2nd[k] === 1'b1);
        end
    endtask : cnt

    task automatic setp(input int k, input logic [7:0] v, input int w);
        @(posedge sys_clk_in);
        run[k] <= 1'b0;
        repeat (10) @(posedge sys_clk_in);
        wr(k ? ADDR_PRESCALE1 : ADDR_PRESCALE0, v);
        run[k] <= 1'b1;
        repeat (w) @(posedge sys_clk_in);
    endtask : setp

    task automatic t_reset();
        rd_chk(ADDR_PORT7_DIR, 8'hFF);
        rd_chk(ADDR_PRESCALE0, 8'h00);
        rd_chk(ADDR_PRESCALE1, 8'h00);
        rd_chk(ADDR_OUT_CTRL, 8'h00);
        rd_chk(16'hFF00, 8'h00);
        chk8({2'h0, oe_o}, 8'h00);
    endtask : t_reset

    // Pin 1 high through reset, then rising edge enabled twice
    task automatic t_first_rise();
        int t, f, s;
        setp(1, {2'h0, EDGE_RISE, 2'h0, CSEL_EXT}, 0);
        cnt(1, 20, t, f, s);
        chkn(f, 1);
        setp(1, {2'h0, EDGE_RISE, 2'h0, CSEL_EXT}, 0);
        cnt(1, 20, t, f, s);
        chkn(f, 0);
        pin1 <= 1'b0;
        repeat (20) @(posedge sys_clk_in);
        pin1 <= 1'b1;
        @(posedge sys_clk_in) pin1 <= 1'b0;
        cnt(1, 20, t, f, s);
        chkn(f, 0);
        pin1 <= 1'b1;
        cnt(1, 20, t, f, s);
        chkn(t, 1);
    endtask : t_first_rise

    task automatic t_taps();
        int t, f, s;
        int ex [2][3] = '{'{0, 2, 6}, '{1, 3, 9}};
        for (int k = 0; k < 2; k++) begin
            for (int c = 0; c < 3; c++) begin
                setp(k, {6'h00, 2'(c)}, 12);
                cnt(k, 1024, t, f, s);
                chkn(t, 1024 >> ex[k][c]);
            end
        end
    endtask : t_taps

    // Eight source periods per window, every edge code
    // no capture or clear-and-start on the counted pin edge; first_edge_out still pulses on it here
    task automatic t_edges();
        int t, f, s;
        logic [1:0] cd [4] = '{EDGE_FALL, EDGE_RISE, 2'h2, EDGE_BOTH};
        int ne [4] = '{8, 8, 0, 16};
        src_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            setp(0, {cd[i], cd[i], 2'h0, CSEL_EXT}, 20);
            cnt(0, 320, t, f, s);
            chkn(f, ne[i]);
            chkn(s, ne[i]);
            chkn(t, ne[i]);
        end
    endtask : t_edges

    // Pins as outputs: edges lost, latch and timer level on the pins
    task automatic t_dir();
        int t, f, s;
        src_en <= 1'b0;
        repeat (20) @(posedge sys_clk_in);
        wr(ADDR_PORT7_DIR, 8'h00);
        rd_chk(ADDR_PORT7_DIR, 8'hC0);
        wr(ADDR_PORT7_LATCH, 8'h1E);
        t0_lvl <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        chk8({2'h0, oe_o}, 8'h3F);
        chk8({2'h0, pin_o}, 8'h1F);
        src_en <= 1'b1;
        cnt(0, 320, t, f, s);
        chkn(f, 0);
        src_en <= 1'b0;
        t0_lvl <= 1'b0;
        repeat (20) @(posedge sys_clk_in);
        wr(ADDR_PORT7_DIR, 8'hFF);
    endtask : t_dir

    // counter 1 stopped before control changes
    task automatic t_ctrl();
        run[1] <= 1'b0;
        wr(ADDR_OUT_CTRL, 8'h1B);
        #1 chk8({7'h0, ff}, 8'h01);
        rd_chk(ADDR_OUT_CTRL, 8'h13);
        wr(ADDR_OUT_CTRL, 8'h17);
        wr(ADDR_OUT_CTRL, 8'h1F);
        #1 chk8({7'h0, ff}, 8'h00);
        wr(ADDR_OUT_CTRL, 8'h03);
        m_a <= 1'b1;
        @(posedge sys_clk_in) m_a <= 1'b0;
        wr(ADDR_OUT_CTRL, 8'h11);
        #1 chk8({7'h0, ff}, 8'h01);
        chk8({7'h0, pin_o[SHARED_PIN5]}, 8'h01);
        m_b <= 1'b1;
        @(posedge sys_clk_in) m_b <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1 chk8({7'h0, ff}, 8'h00);
    endtask : t_ctrl

    // Watchdog well past the expected run of about 8200 cycles
    initial begin
        #500000;
        bad_count++;
        finish_test();
    end

    initial begin
        reset_n_in = 1'b0;
        run = 2'h0;
        req = '0;
        src_en = 1'b0;
        pin1 = 1'b1;
        t0_lvl = 1'b0;
        m_a = 1'b0;
        m_b = 1'b0;
        repeat (4) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_first_rise();
        t_taps();
        t_edges();
        t_dir();
        t_ctrl();
        finish_test();
    end
endmodule : tpe_timer_prescaler_tb
